// *** rtl/scan_port.sv ***
// Boundary-scan test port with word FIFO toward the system clock domain
`timescale 1ns/1ps

module scan_word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_depth
		$error("FIFO depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [PW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (PW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk) begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end

	fifo_count_a: assert property (@(posedge clk) disable iff (rst)
		count_ff <= (PW+1)'(DEPTH))
		else $error("FIFO count beyond depth");
endmodule // scan_word_fifo

// Functional notes
// - Test reset input low resets the test port logic at once, except the word handshake, which only RST resets.
// - Mode select is sampled on every rising test clock edge.
// - Test data input enters the selected scan path on rising test clock edges.
// - Serial output changes only on falling test clock edges and on test reset.
// - With test clock stopped low, all test logic keeps its state.
// - Serial output is high impedance except while shifting a scan path.
// - Undriven pins default: test reset low, mode select and data input high.
module scan_port
	import scan_port_pkg::*;
#(
	parameter int DEPTH = scan_port_pkg::FIFO_DEPTH
) (
	input  wire logic                              SYS_CLK,
	input  wire logic                              RST,
	input  wire logic                              TCK,
	input  wire logic                              TRST_N,
	input  wire logic                              TMS,
	input  wire logic                              TDI,
	output logic                                   TDO_O,
	output logic                                   TDO_OE,
	output logic      [scan_port_pkg::DR_WIDTH-1:0] WORD_DATA,
	output logic                                   WORD_VALID,
	input  wire logic                              WORD_READY
);
	import scan_port_pkg::*;

	// Test clock domain
	logic                tap_rst;
	tap_state_type       state_ff;
	tap_state_type       nxt_state;
	logic [IR_WIDTH-1:0] ir_shift_ff;
	logic [IR_WIDTH-1:0] ir_ff;
	logic [DR_WIDTH-1:0] dr_shift_ff;
	logic                bypass_ff;
	logic [DR_WIDTH-1:0] word_hold_ff;
	logic                req_tgl_ff;
	logic                ack_meta_ff;
	logic                ack_sync_ff;
	logic                ovf_ff;
	logic                tdo_ff;
	logic                tdo_oe_ff;
	logic                busy;
	logic                data_sel;
	logic                nxt_tdo;

	// System clock domain
	logic                req_meta_ff;
	logic                req_sync_ff;
	logic                req_seen_ff;
	logic                pend_ff;
	logic [DR_WIDTH-1:0] pend_data_ff;
	logic                ack_tgl_ff;
	logic                fifo_in_ready;
	logic                new_word;

	// Pads pull an open reset low, so an unused port stays in reset
	assign tap_rst  = RST || !TRST_N;
	assign data_sel = (ir_ff == IR_DATA_CODE);
	assign busy     = req_tgl_ff ^ ack_sync_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET:    nxt_state = TMS ? ST_RESET : ST_IDLE;
			ST_IDLE:     nxt_state = TMS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   nxt_state = TMS ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   nxt_state = TMS ? ST_EX1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: nxt_state = TMS ? ST_EX1_DR : ST_SHIFT_DR;
			ST_EX1_DR:   nxt_state = TMS ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: nxt_state = TMS ? ST_EX2_DR : ST_PAUSE_DR;
			ST_EX2_DR:   nxt_state = TMS ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   nxt_state = TMS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   nxt_state = TMS ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   nxt_state = TMS ? ST_EX1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: nxt_state = TMS ? ST_EX1_IR : ST_SHIFT_IR;
			ST_EX1_IR:   nxt_state = TMS ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: nxt_state = TMS ? ST_EX2_IR : ST_PAUSE_IR;
			ST_EX2_IR:   nxt_state = TMS ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   nxt_state = TMS ? ST_SEL_DR : ST_IDLE;
			default:     nxt_state = ST_RESET;
		endcase
	end

	// All test-side state moves on TCK edges or on reset only, so a stopped clock holds it
	always_ff @(posedge TCK or posedge tap_rst) begin
		if (tap_rst)
			state_ff <= ST_RESET;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge TCK or posedge tap_rst) begin
		if (tap_rst) begin
			ir_shift_ff <= IR_RESET_CODE;
			ir_ff       <= IR_RESET_CODE;
		end else begin
			if (state_ff == ST_CAP_IR)
				ir_shift_ff <= IR_CAPTURE_CODE;
			else if (state_ff == ST_SHIFT_IR)
				ir_shift_ff <= {TDI, ir_shift_ff[IR_WIDTH-1:1]};
			if (state_ff == ST_UPD_IR)
				ir_ff <= ir_shift_ff;
			else if (state_ff == ST_RESET)
				ir_ff <= IR_RESET_CODE;
		end
	end

	always_ff @(posedge TCK or posedge tap_rst) begin
		if (tap_rst) begin
			dr_shift_ff <= '0;
			bypass_ff   <= 1'b0;
		end else begin
			if (state_ff == ST_CAP_DR) begin
				dr_shift_ff <= {busy, ovf_ff, DR_STATUS_PAD};
				bypass_ff   <= 1'b0;
			end else if (state_ff == ST_SHIFT_DR) begin
				if (data_sel)
					dr_shift_ff <= {TDI, dr_shift_ff[DR_WIDTH-1:1]};
				else
					bypass_ff <= TDI;
			end
		end
	end

	// Handshake toggles reset only with RST: a test reset alone must not fake a word
	always_ff @(posedge TCK or posedge RST) begin
		if (RST) begin
			word_hold_ff <= '0;
			req_tgl_ff   <= 1'b0;
		end else if (state_ff == ST_UPD_DR && data_sel && !busy) begin
			word_hold_ff <= dr_shift_ff;
			req_tgl_ff   <= !req_tgl_ff;
		end
	end

	// A word updated while the previous one is still unacknowledged is dropped
	always_ff @(posedge TCK or posedge tap_rst) begin
		if (tap_rst)
			ovf_ff <= 1'b0;
		else if (state_ff == ST_UPD_DR && data_sel && busy)
			ovf_ff <= 1'b1;
		else if (state_ff == ST_CAP_DR && data_sel)
			ovf_ff <= 1'b0;
	end

	always_ff @(posedge TCK or posedge RST) begin
		if (RST) begin
			ack_meta_ff <= 1'b0;
			ack_sync_ff <= 1'b0;
		end else begin
			ack_meta_ff <= ack_tgl_ff;
			ack_sync_ff <= ack_meta_ff;
		end
	end

	always_comb begin
		nxt_tdo = 1'b1;
		if (state_ff == ST_SHIFT_IR)
			nxt_tdo = ir_shift_ff[0];
		else if (state_ff == ST_SHIFT_DR)
			nxt_tdo = data_sel ? dr_shift_ff[0] : bypass_ff;
	end

	always_ff @(negedge TCK or posedge tap_rst) begin
		if (tap_rst) begin
			tdo_ff    <= 1'b1;
			tdo_oe_ff <= 1'b0;
		end else begin
			tdo_ff    <= nxt_tdo;
			tdo_oe_ff <= (state_ff == ST_SHIFT_DR) || (state_ff == ST_SHIFT_IR);
		end
	end

	assign TDO_O  = tdo_ff;
	assign TDO_OE = tdo_oe_ff;

	// System side: catch the request toggle and hold the word until the FIFO takes it
	assign new_word = req_sync_ff ^ req_seen_ff;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			req_meta_ff <= 1'b0;
			req_sync_ff <= 1'b0;
			req_seen_ff <= 1'b0;
		end else begin
			req_meta_ff <= req_tgl_ff;
			req_sync_ff <= req_meta_ff;
			req_seen_ff <= req_sync_ff;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pend_ff      <= 1'b0;
			pend_data_ff <= '0;
			ack_tgl_ff   <= 1'b0;
		end else begin
			if (new_word) begin
				pend_ff      <= 1'b1;
				pend_data_ff <= word_hold_ff;
			end else if (pend_ff && fifo_in_ready) begin
				pend_ff    <= 1'b0;
				ack_tgl_ff <= !ack_tgl_ff;
			end
		end
	end

	scan_word_fifo #(
		.WIDTH (DR_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_data   (pend_data_ff),
		.in_valid  (pend_ff),
		.in_ready  (fifo_in_ready),
		.out_data  (WORD_DATA),
		.out_valid (WORD_VALID),
		.out_ready (WORD_READY)
	);

	// Checks on the test clock side
	sequence tms_high_five;
		TMS [*5];
	endsequence

	sequence enter_shift_dr;
		(state_ff == ST_CAP_DR) && !TMS;
	endsequence

	tap_reset_a: assert property (@(posedge TCK) tap_rst |-> state_ff == ST_RESET)
		else $error("Test port not in reset during reset");

	five_tms_a: assert property (@(posedge TCK) disable iff (tap_rst)
		tms_high_five |=> state_ff == ST_RESET)
		else $error("Five high mode select edges did not reach reset");

	idle_step_a: assert property (@(posedge TCK) disable iff (tap_rst)
		(state_ff == ST_IDLE) && TMS |=> state_ff == ST_SEL_DR)
		else $error("Idle did not advance on mode select high");

	shift_entry_a: assert property (@(posedge TCK) disable iff (tap_rst)
		enter_shift_dr ##1 !TMS |=> state_ff == ST_SHIFT_DR)
		else $error("Capture did not lead into shift");

	dr_capture_a: assert property (@(posedge TCK) disable iff (tap_rst)
		(state_ff == ST_SHIFT_DR) && data_sel |=> dr_shift_ff[DR_WIDTH-1] == $past(TDI))
		else $error("Data input not captured into scan path");

	tdo_zone_a: assert property (@(posedge TCK) disable iff (tap_rst)
		TDO_OE == ((state_ff == ST_SHIFT_DR) || (state_ff == ST_SHIFT_IR)))
		else $error("Output enable outside shift states");

	tdo_value_a: assert property (@(posedge TCK) disable iff (tap_rst)
		(state_ff == ST_SHIFT_DR) && data_sel && TDO_OE |-> TDO_O == dr_shift_ff[0])
		else $error("Serial output not set up before rising edge");

	ir_update_a: assert property (@(posedge TCK) disable iff (tap_rst)
		state_ff == ST_UPD_IR |=> ir_ff == $past(ir_shift_ff))
		else $error("Instruction not updated");

	// Checks on the system side
	word_held_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		pend_ff && !fifo_in_ready |=> pend_ff && $stable(pend_data_ff))
		else $error("Pending word lost under back-pressure");

	word_push_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		new_word |=> pend_ff ##1 (pend_ff || $changed(ack_tgl_ff)))
		else $error("Crossed word not taken");
endmodule // scan_port

// *** rtl/scan_port_pkg.sv ***
// Shared constants and types for the boundary-scan test port
package scan_port_pkg;

	localparam int IR_WIDTH   = 2;
	localparam int DR_WIDTH   = 8;
	localparam int FIFO_DEPTH = 4;

	localparam logic [1:0] IR_DATA_CODE    = 2'h1;
	localparam logic [1:0] IR_BYPASS_CODE  = 2'h3;
	localparam logic [1:0] IR_CAPTURE_CODE = 2'h1;
	localparam logic [1:0] IR_RESET_CODE   = 2'h3;
	localparam logic [5:0] DR_STATUS_PAD   = 6'h00;

	typedef enum logic [3:0] {
		ST_RESET    = 4'hF,
		ST_IDLE     = 4'hC,
		ST_SEL_DR   = 4'h7,
		ST_CAP_DR   = 4'h6,
		ST_SHIFT_DR = 4'h2,
		ST_EX1_DR   = 4'h1,
		ST_PAUSE_DR = 4'h3,
		ST_EX2_DR   = 4'h0,
		ST_UPD_DR   = 4'h5,
		ST_SEL_IR   = 4'h4,
		ST_CAP_IR   = 4'hE,
		ST_SHIFT_IR = 4'hA,
		ST_EX1_IR   = 4'h9,
		ST_PAUSE_IR = 4'hB,
		ST_EX2_IR   = 4'h8,
		ST_UPD_IR   = 4'hD
	} tap_state_type;

endpackage

// *** verif/scan_ctrl_model.sv ***
// Behavioural model of the external test controller on the scan link
`timescale 1ns/1ps

module scan_ctrl_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo
);
	// Link clock stands low outside frames; idle levels follow the pad pulls
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b0;
	end

	// One link clock: inputs set while low, serial output taken at the rising edge
	task automatic pulse(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5 tck = 1'b1;
		o = tdo;
		#62.5 tck = 1'b0;
	endtask

	task automatic trst_cycle();
		tms = 1'b1;
		trst_n = 1'b0;
		#300 trst_n = 1'b1;
		#100;
	endtask

	task automatic idle(input int n);
		logic o;
		for (int i = 0; i < n; i++) begin
			pulse(1'b0, 1'b1, o);
		end
	endtask

	// Idle to scan and back to idle; the clock may stop low in mid-shift
	task automatic scan(input logic ir, input int n, input logic [7:0] din, input int stall,
			output logic [7:0] dout);
		logic o;
		dout = 8'h00;
		pulse(1'b1, 1'b1, o);
		if (ir) begin
			pulse(1'b1, 1'b1, o);
		end
		pulse(1'b0, 1'b1, o);
		pulse(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, din[i], o);
			dout[i] = o;
			if (i == n / 2) begin
				#(stall);
			end
		end
		pulse(1'b1, 1'b1, o);
		idle(3);
	endtask
endmodule // scan_ctrl_model

// *** verif/tb_scan_port.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps

module tb_scan_port;
	import scan_port_pkg::*;

	logic       SYS_CLK    = 1'b0;
	logic       RST        = 1'b1;
	logic       WORD_READY = 1'b0;
	logic       TCK, TMS, TDI, TRST_N, TDO_O, TDO_OE, WORD_VALID, b;
	logic [7:0] WORD_DATA, dout, w, e;
	wire        tdo = TDO_OE ? TDO_O : 1'bz;
	int         err_count = 0;
	int         tests_run = 0;
	logic [7:0] q[$];
	logic       ovf = 1'b0;

	always #5 SYS_CLK = ~SYS_CLK;

	scan_port #(.DEPTH(FIFO_DEPTH)) dut (.SYS_CLK(SYS_CLK), .RST(RST), .TCK(TCK),
		.TRST_N(TRST_N), .TMS(TMS), .TDI(TDI), .TDO_O(TDO_O), .TDO_OE(TDO_OE),
		.WORD_DATA(WORD_DATA), .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY));
	scan_ctrl_model ctrl (.tck(TCK), .tms(TMS), .tdi(TDI), .trst_n(TRST_N), .tdo(tdo));

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Status seen at capture: busy once a word waits behind a full FIFO
	function automatic logic [7:0] status_exp(input int held, input logic o);
		return {held > FIFO_DEPTH, o, DR_STATUS_PAD};
	endfunction

	always @(TDO_O or TDO_OE) begin
		if (TCK === 1'b1) begin
			err_count++;
			$display("BAD t=%0t serial output moved while link clock high", $time);
		end
	end

	task automatic send_word();
		w = 8'($urandom);
		e = status_exp(q.size(), ovf);
		ovf = 1'b0;
		ctrl.scan(1'b0, 8, w, 2000 * $urandom_range(0, 1), dout);
		check(dout, e, "status");
		if (q.size() > FIFO_DEPTH) begin
			ovf = 1'b1;
		end else begin
			q.push_back(w);
		end
		check(8'(TDO_OE), 8'h00, "oe idle");
	endtask

	task automatic pop_word();
		int n = 0;
		@(negedge SYS_CLK);
		while (WORD_VALID !== 1'b1) begin
			@(negedge SYS_CLK);
			n++;
			if (n > 200) begin
				err_count++;
				$display("BAD t=%0t no word arrived", $time);
				stop_test();
			end
		end
		check(WORD_DATA, q.pop_front(), "word");
		@(posedge SYS_CLK);
		WORD_READY <= 1'b1;
		@(posedge SYS_CLK);
		WORD_READY <= 1'b0;
	endtask

	initial begin
		void'($urandom(32'h0D524FB1));
		repeat (4) @(posedge SYS_CLK);
		RST <= 1'b0;
		check(8'(TDO_OE), 8'h00, "oe reset");
		ctrl.trst_cycle();
		repeat (3) ctrl.pulse(1'($urandom), 1'b1, b);
		repeat (5) ctrl.pulse(1'b1, 1'b1, b);
		ctrl.idle(1);
		ctrl.scan(1'b1, 2, {6'h00, IR_DATA_CODE}, 0, dout);
		check(dout, {6'h00, IR_CAPTURE_CODE}, "ir capture");
		$display("test ir load done");
		repeat (7) send_word();
		while (q.size() > 0) pop_word();
		ctrl.idle(4);
		$display("test overflow done");
		repeat (6) begin
			send_word();
			repeat ($urandom_range(0, 5)) @(posedge SYS_CLK);
			pop_word();
		end
		$display("test stream done");
		ctrl.trst_cycle();
		check(8'(TDO_OE), 8'h00, "oe after test reset");
		ctrl.idle(1);
		w = 8'($urandom);
		ctrl.scan(1'b0, 8, w, 0, dout);
		check(dout, {w[6:0], 1'b0}, "bypass path");
		check(8'(WORD_VALID), 8'h00, "no word via bypass");
		$display("test link reset done");
		stop_test();
	end
endmodule // tb_scan_port
